// ===== eec_pkg.sv
package eec_pkg;

    // clock rate and programming timing
    localparam int CLK_MHZ = 100;
    localparam int ERASE_TIME_US = 5000;
    localparam int WRITE_TIME_US = 5000;
    localparam int POR_TIME_US = 20;
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;

    // widths and fixed values
    localparam int TIMER_W = 20;
    localparam int POR_W = 12;
    localparam int ADDR_W = 9;
    localparam logic [3:0] DEV_PATTERN = 4'ha;
    localparam logic [3:0] LAST_BIT = 4'h8;
    localparam logic [7:0] ERASED_WORD = 8'hff;
    localparam logic [8:0] LAST_WORD = 9'h1ff;

    // serial front end sequence
    typedef enum logic [2:0] {
        B_IDLE = 3'b000,
        B_SEL = 3'b001,
        B_ADDR = 3'b010,
        B_DATA = 3'b011,
        B_ARMED = 3'b100,
        B_READ = 3'b101,
        B_WAIT = 3'b110
    } eec_bus_t;

    // programming sequencer
    typedef enum logic [1:0] {
        P_IDLE = 2'b00,
        P_ERASE = 2'b01,
        P_WRITE = 2'b10,
        P_SWEEP = 2'b11
    } eec_prog_t;

    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic [1:0] sel0_sync;
        logic [1:0] sel0_open_sync;
        logic [1:0] sel2_open_sync;
        logic scl_prev;
        logic sda_prev;
        eec_bus_t bst;
        eec_bus_t nxt;
        logic [3:0] cnt;
        logic in_ack;
        logic rdfirst;
        logic mack;
        logic [7:0] rx;
        logic [7:0] tx;
        logic [8:0] addr;
        logic a9;
        logic [7:0] data;
        logic oe;
        logic drv;
        eec_prog_t ps;
        logic total;
        logic [TIMER_W-1:0] timer;
        logic [8:0] pa;
        logic [7:0] pdata;
        logic busy;
        logic lock;
        logic [POR_W-1:0] por_cnt;
    } eec_state_t;

    localparam eec_state_t ST_RESET = '{scl_sync: 2'b11, sda_sync: 2'b11, scl_prev: 1'b1,
        sda_prev: 1'b1, bst: B_IDLE, nxt: B_IDLE, ps: P_IDLE, lock: 1'b1, default: '0};

endpackage : eec_pkg

// ===== eec_slave.sv
`timescale 1ns/100ps
// Operation
// - scl high: sda falling is start, sda rising is stop
// - sda changes only while scl low; sampled while scl high
// - on select match, pull sda low from clock eight fall through clock nine
// - release sda during clock nine when sending read data
// - programming starts only on stop after the 27th clock
// - respond only when select bit zero equals select input zero
// - address bits eight and nine come from the write-select byte
// - write-select during programming aborts programming
// - read-select ignored and unacknowledged while programming runs
// - load word on ack clock nine, drive bits from its falling edge
// - increment address after a byte when master acknowledges low
// - sequential read address wraps from 511 to 0
// - stop releases sda and returns sequence to idle
// - programming erases word to ones, then writes the zero bits
// - erase plus write completes within 20 ms, about 10 ms typical
// - skip write with no zero bits, skip erase of erased word
// - after power-up sda released and programming refused for a while
// - word 0, data FF, select two open at stop: erase whole array
// - select zero floating: no programming, answer only select bit zero clear
// - select byte: pattern 1010, A9, A8, select bit zero, read/write bit
module eec_slave #(
    parameter int ERASE_CYCLES = eec_pkg::ERASE_CYCLES,
    parameter int WRITE_CYCLES = eec_pkg::WRITE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial bus pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // select straps
    input wire logic select_input_zero,
    input wire logic select_input_zero_open,
    input wire logic select_input_two_open,
    // status
    output logic prog_busy,
    output logic por_lockout
);

    eec_pkg::eec_state_t s;
    eec_pkg::eec_state_t n;
    logic [7:0] mem [0:511];
    logic mem_we;
    logic [8:0] mem_wa;
    logic [7:0] mem_wd;
    logic scl_now;
    logic sda_now;
    logic sel0;
    logic sel0_open;
    logic sel2_open;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic sel_eval;
    logic cs_match;
    logic [8:0] rd_addr;
    logic [7:0] rd_word;
    logic [7:0] cur_word;

    // second synchroniser stage only; first stage feeds nothing else
    assign scl_now = s.scl_sync[1];
    assign sda_now = s.sda_sync[1];
    assign sel0 = s.sel0_sync[1];
    assign sel0_open = s.sel0_open_sync[1];
    assign sel2_open = s.sel2_open_sync[1];

    // bus events seen on the system clock
    assign scl_rise = scl_now & ~s.scl_prev;
    assign scl_fall = ~scl_now & s.scl_prev;
    assign start_c = scl_now & s.scl_prev & s.sda_prev & ~sda_now;
    assign stop_c = scl_now & s.scl_prev & ~s.sda_prev & sda_now;
    assign sel_eval = scl_fall && s.bst == eec_pkg::B_SEL && s.cnt == eec_pkg::LAST_BIT
        && !s.in_ack;

    // pattern check; select bit match; floating strap forces zero
    assign cs_match = (s.rx[7:4] == eec_pkg::DEV_PATTERN)
        && (sel0_open ? !s.rx[1] : (s.rx[1] == sel0));

    // nine-bit counter wraps naturally past the last word
    assign rd_addr = s.rdfirst ? s.addr : s.addr + 9'h001;
    assign rd_word = mem[rd_addr];
    assign cur_word = mem[s.addr];

    // next-state logic for the whole block
    always_comb begin
        n = s;
        mem_we = 1'b0;
        mem_wa = s.pa;
        mem_wd = eec_pkg::ERASED_WORD;
        n.scl_sync = {s.scl_sync[0], scl};
        n.sda_sync = {s.sda_sync[0], sda_in};
        n.sel0_sync = {s.sel0_sync[0], select_input_zero};
        n.sel0_open_sync = {s.sel0_open_sync[0], select_input_zero_open};
        n.sel2_open_sync = {s.sel2_open_sync[0], select_input_two_open};
        n.scl_prev = scl_now;
        n.sda_prev = sda_now;

        if (s.lock) begin
            if (s.por_cnt == eec_pkg::POR_W'(eec_pkg::POR_CYCLES - 1)) begin
                n.lock = 1'b0;
            end else begin
                n.por_cnt = s.por_cnt + 1'b1;
            end
        end

        // erase then write; phase timers; sweep for total erase
        unique case (s.ps)
            eec_pkg::P_IDLE: begin
                n.timer = '0;
            end
            eec_pkg::P_ERASE: begin
                if (s.timer == eec_pkg::TIMER_W'(ERASE_CYCLES - 1)) begin
                    n.timer = '0;
                    if (s.total) begin
                        n.ps = eec_pkg::P_SWEEP;
                        n.pa = '0;
                    end else begin
                        mem_we = 1'b1;
                        // no write phase without zero bits
                        if (s.pdata != eec_pkg::ERASED_WORD) begin
                            n.ps = eec_pkg::P_WRITE;
                        end else begin
                            n.ps = eec_pkg::P_IDLE;
                            n.busy = 1'b0;
                        end
                    end
                end else begin
                    n.timer = s.timer + 1'b1;
                end
            end
            eec_pkg::P_WRITE: begin
                if (s.timer == eec_pkg::TIMER_W'(WRITE_CYCLES - 1)) begin
                    mem_we = 1'b1;
                    mem_wd = s.pdata;
                    n.ps = eec_pkg::P_IDLE;
                    n.busy = 1'b0;
                end else begin
                    n.timer = s.timer + 1'b1;
                end
            end
            eec_pkg::P_SWEEP: begin
                mem_we = 1'b1;
                n.pa = s.pa + 9'h001;
                if (s.pa == eec_pkg::LAST_WORD) begin
                    n.ps = eec_pkg::P_IDLE;
                    n.busy = 1'b0;
                    n.total = 1'b0;
                end
            end
        endcase

        // bus sequence: start and stop win over clock edges
        if (start_c) begin
            n.bst = eec_pkg::B_SEL;
            n.cnt = '0;
            n.in_ack = 1'b0;
            n.oe = 1'b0;
        end else if (stop_c) begin
            // only the armed state launches programming; others never do
            if (s.bst == eec_pkg::B_ARMED && !s.lock && !sel0_open && !s.busy) begin
                n.pa = s.addr;
                n.pdata = s.data;
                n.timer = '0;
                n.total = sel2_open && s.addr == '0 && s.data == eec_pkg::ERASED_WORD;
                if (n.total || cur_word != eec_pkg::ERASED_WORD) begin
                    n.ps = eec_pkg::P_ERASE;
                    n.busy = 1'b1;
                end else if (s.data != eec_pkg::ERASED_WORD) begin
                    // word already erased, go straight to write
                    n.ps = eec_pkg::P_WRITE;
                    n.busy = 1'b1;
                end
            end
            n.bst = eec_pkg::B_IDLE;
            n.in_ack = 1'b0;
            n.oe = 1'b0;
        end else if (s.bst != eec_pkg::B_IDLE && s.bst != eec_pkg::B_WAIT) begin
            if (scl_rise) begin
                // sample only on the rising clock
                if (s.bst == eec_pkg::B_ARMED) begin
                    // the stop needs this rise, so stay armed for it
                    n.bst = eec_pkg::B_ARMED;
                end else if (s.cnt != eec_pkg::LAST_BIT) begin
                    n.cnt = s.cnt + 1'b1;
                    n.rx = {s.rx[6:0], sda_now};
                end else begin
                    n.mack = sda_now;
                end
            end else if (scl_fall && s.bst == eec_pkg::B_ARMED) begin
                // a 28th clock fell with no stop: disarm until the next start
                n.bst = eec_pkg::B_WAIT;
            end else if (scl_fall) begin
                if (s.cnt != eec_pkg::LAST_BIT) begin
                    // one further bit per falling clock
                    if (s.bst == eec_pkg::B_READ) begin
                        n.tx = {s.tx[6:0], 1'b0};
                        n.oe = ~s.tx[6];
                    end
                end else if (!s.in_ack) begin
                    // acknowledge starts at the fall of clock eight
                    n.in_ack = 1'b1;
                    n.oe = 1'b1;
                    unique case (s.bst)
                        eec_pkg::B_SEL: begin
                            if (!cs_match) begin
                                n.bst = eec_pkg::B_WAIT;
                                n.in_ack = 1'b0;
                                n.oe = 1'b0;
                            end else if (!s.rx[0]) begin
                                n.addr[8] = s.rx[2];
                                n.a9 = s.rx[3];
                                n.nxt = eec_pkg::B_ADDR;
                                if (s.busy) begin
                                    n.ps = eec_pkg::P_IDLE;
                                    n.busy = 1'b0;
                                    n.total = 1'b0;
                                    mem_we = 1'b0;
                                end
                            end else if (s.busy) begin
                                // no answer to read-select while busy
                                n.bst = eec_pkg::B_WAIT;
                                n.in_ack = 1'b0;
                                n.oe = 1'b0;
                            end else begin
                                n.nxt = eec_pkg::B_READ;
                                n.rdfirst = 1'b1;
                            end
                        end
                        eec_pkg::B_ADDR: begin
                            n.addr[7:0] = s.rx;
                            n.nxt = eec_pkg::B_DATA;
                        end
                        eec_pkg::B_DATA: begin
                            n.data = s.rx;
                            n.nxt = eec_pkg::B_ARMED;
                        end
                        default: begin
                            // read data: line released for master ack
                            n.oe = 1'b0;
                            n.nxt = eec_pkg::B_READ;
                        end
                    endcase
                end else begin
                    // end of clock nine
                    n.in_ack = 1'b0;
                    n.cnt = '0;
                    n.oe = 1'b0;
                    n.bst = s.nxt;
                    if (s.nxt == eec_pkg::B_READ) begin
                        // advance only on master ack low; parallel load
                        if (s.rdfirst || !s.mack) begin
                            n.addr = rd_addr;
                            n.tx = rd_word;
                            n.oe = ~rd_word[7];
                            n.rdfirst = 1'b0;
                        end else begin
                            n.bst = eec_pkg::B_WAIT;
                        end
                    end
                end
            end
        end
    end

    // single state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= eec_pkg::ST_RESET;
        end else begin
            s <= n;
        end
    end

    // array has no reset; contents survive like the cells they model
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // outputs come straight from state flops; line is open drain
    assign sda_out = s.drv;
    assign sda_oe = s.oe;
    assign prog_busy = s.busy;
    assign por_lockout = s.lock;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence ack_open_s;
        sel_eval && cs_match && !s.rx[0];
    endsequence
    sequence ack_end_s;
        scl_fall && s.in_ack && !start_c && !stop_c;
    endsequence

    start_seq_a: assert property (start_c |=> s.bst == eec_pkg::B_SEL && s.cnt == '0)
        else $error("start not taken");
    stop_idle_a: assert property (stop_c |=> s.bst == eec_pkg::B_IDLE && !sda_oe)
        else $error("stop did not release bus");
    // drive starts only in low clock
    drive_low_a: assert property ($rose(s.oe) |-> !$past(scl_now))
        else $error("sda driven while scl high");
    ack_hold_a: assert property (ack_open_s |=> sda_oe && s.in_ack)
        else $error("write select not acknowledged");
    read_release_a: assert property (s.bst == eec_pkg::B_READ && s.in_ack |-> !sda_oe)
        else $error("sda held during master ack");
    busy_read_a: assert property (sel_eval && cs_match && s.rx[0] && s.busy
        |=> !sda_oe && s.bst == eec_pkg::B_WAIT)
        else $error("read select answered while busy");
    abort_prog_a: assert property (ack_open_s ##0 s.busy |=> !s.busy
        && s.ps == eec_pkg::P_IDLE)
        else $error("programming not aborted");
    no_early_a: assert property (stop_c && s.bst != eec_pkg::B_ARMED && !s.busy
        |=> !s.busy)
        else $error("programming from incomplete sequence");
    arm_prog_a: assert property (stop_c && s.bst == eec_pkg::B_ARMED && !s.busy
        && !s.lock && !sel0_open && s.data != eec_pkg::ERASED_WORD |=> s.busy)
        else $error("armed stop started nothing");
    protect_mode_a: assert property ($rose(s.busy) |-> !$past(sel0_open) && !$past(s.lock))
        else $error("programming while protected");
    addr_wrap_a: assert property (ack_end_s ##0 (s.nxt == eec_pkg::B_READ
        && !s.rdfirst && !s.mack && s.addr == eec_pkg::LAST_WORD) |=> s.addr == '0)
        else $error("read address did not wrap");

endmodule : eec_slave

// ===== eec_master.sv
`timescale 1ns/100ps
module eec_master (
    // clock
    input wire logic clk,
    // bus wires
    input wire logic sda,
    output logic scl,
    output logic pull
);
    // idle bus: clock parked high, data released to the pull-up
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic start();
        tick(1);
        pull <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(8);
        pull <= 1'b1;
        tick(8);
        scl <= 1'b0;
    endtask : start

    task automatic stop();
        tick(1);
        pull <= 1'b1;
        tick(7);
        scl <= 1'b1;
        tick(8);
        pull <= 1'b0;
        tick(8);
    endtask : stop

    // data moves only with clock low
    task automatic put(input logic b);
        tick(1);
        pull <= ~b;
        tick(7);
        scl <= 1'b1;
        tick(8);
        scl <= 1'b0;
    endtask : put

    task automatic get(output logic b);
        tick(1);
        pull <= 1'b0;
        tick(7);
        scl <= 1'b1;
        tick(4);
        b = sda;
        tick(4);
        scl <= 1'b0;
    endtask : get

    // byte msb first plus ack clock
    task automatic wbyte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            put(d[i]);
        end
        get(ack);
    endtask : wbyte

    // nine clocks per read byte, own ack last
    task automatic rbyte(input logic m, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            get(d[i]);
        end
        put(m);
    endtask : rbyte
endmodule : eec_master

// ===== tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
    logic clk, rst, scl, pull, sda, sel0, sel0_open, sel2_open, sda_oe, busy, lock, sdo;
    logic [31:0] seed = 32'h753f;
    logic [7:0] em [512];
    logic [8:0] a;
    logic [7:0] d, q;
    logic [2:0] k3;
    logic k, cs, cs0;
    int failures = 0;
    int n_checks = 0;
    int n;

    // open-drain wire: device level while enabled, pulled up otherwise, master pulls low
    assign sda = (sda_oe ? sdo : 1'b1) & ~pull;

    eec_slave #(.ERASE_CYCLES(1000), .WRITE_CYCLES(1000)) DUT (.clk(clk), .rst(rst),
        .scl(scl), .sda_in(sda), .sda_out(sdo), .sda_oe(sda_oe), .select_input_zero(sel0),
        .select_input_zero_open(sel0_open), .select_input_two_open(sel2_open),
        .prog_busy(busy), .por_lockout(lock));
    eec_master M (.clk(clk), .sda(sda), .scl(scl), .pull(pull));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // select byte: pattern, A9 clear, A8, chip bit, direction
    function automatic logic [7:0] sb(input logic a8, input logic c, input logic r);
        return {eec_pkg::DEV_PATTERN, 1'b0, a8, c, r};
    endfunction : sb

    task automatic wait_n(input int c);
        repeat (c) @(posedge clk);
    endtask : wait_n

    task automatic wr(input logic [8:0] wa, input logic [7:0] wd, input logic te);
        M.start();
        M.wbyte(sb(wa[8], cs, 1'b0), k3[2]);
        M.wbyte(wa[7:0], k3[1]);
        M.wbyte(wd, k3[0]);
        if (te) begin
            sel2_open <= 1'b1;
        end
        M.stop();
        wait_n(5);
    endtask : wr

    // random read: dummy write select, address, repeated start, read select
    task automatic rd(input logic [8:0] ra, input logic m);
        M.start();
        M.wbyte(sb(ra[8], cs, 1'b0), k);
        M.wbyte(ra[7:0], k);
        M.start();
        M.wbyte(sb(ra[8], cs, 1'b1), k);
        M.rbyte(m, q);
    endtask : rd

    task automatic idle();
        n = 0;
        while (busy !== 1'b0 && n < 2500) begin
            @(posedge clk);
            n++;
        end
        `CHK("busy end", 1'b0, busy)
    endtask : idle

    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // watchdog: run needs about 24000 clocks
    initial begin
        wait_n(70000);
        failures++;
        report_and_stop();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        sel0 = 1'b0;
        sel0_open = 1'b0;
        sel2_open = 1'b0;
        wait_n(6);
        rst <= 1'b0;
        seed = xs(seed);
        sel0 <= seed[0];
        cs0 = seed[0];
        cs = cs0;
        wait_n(1);
        `CHK("oe after reset", 1'b0, sda_oe)
        `CHK("lockout", 1'b1, lock)
        wr(9'h005, 8'h00, 1'b0);
        `CHK("busy in lockout", 1'b0, busy)
        n = 0;
        while (lock !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        `CHK("lockout end", 1'b0, lock)
        // write then read back, corner words first
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            a = (i == 0) ? 9'h1ff : (i == 1) ? 9'h000 : seed[8:0];
            d = seed[23:16] & 8'h7f;
            wr(a, d, 1'b0);
            `CHK("write acks", 3'b000, k3)
            `CHK("drive level", 1'b0, sdo)
            `CHK("busy after stop", 1'b1, busy)
            idle();
            em[a] = d;
            rd(a, 1'b1);
            M.stop();
            `CHK("read ack", 1'b0, k)
            `CHK("read data", em[a], q)
            wait_n(4);
            `CHK("oe after stop", 1'b0, sda_oe)
        end
        // sequential read over the top word
        rd(9'h1ff, 1'b0);
        `CHK("word 511", em[511], q)
        M.rbyte(1'b1, q);
        `CHK("wrapped word 0", em[0], q)
        M.stop();
        wait_n(4);
        `CHK("oe released", 1'b0, sda_oe)
        M.start();
        M.wbyte(sb(1'b0, ~cs, 1'b0), k);
        `CHK("foreign select", 1'b1, k)
        M.stop();
        M.start();
        M.wbyte(sb(1'b0, cs, 1'b0), k);
        M.wbyte(8'h10, k);
        M.stop();
        wait_n(5);
        `CHK("short sequence", 1'b0, busy)
        // completion polling with read select
        wr(9'h000, 8'hff, 1'b0);
        n = 0;
        k = 1'b1;
        while (k !== 1'b0 && n < 40) begin
            M.start();
            M.wbyte(sb(1'b0, cs, 1'b1), k);
            if (n == 0) begin
                `CHK("poll while busy", 1'b1, k)
            end
            if (k === 1'b0) begin
                `CHK("busy at poll ack", 1'b0, busy)
                M.rbyte(1'b1, q);
            end
            M.stop();
            n++;
        end
        em[0] = 8'hff;
        `CHK("polled data", em[0], q)
        // abort by write select
        wr(9'h1ff, 8'h00, 1'b0);
        M.start();
        M.wbyte(sb(1'b1, cs, 1'b0), k);
        wait_n(5);
        `CHK("aborted", 1'b0, busy)
        M.stop();
        // protect mode
        sel0_open <= 1'b1;
        cs = 1'b0;
        seed = xs(seed);
        wr(9'h000, seed[7:0] & 8'h7f, 1'b0);
        `CHK("protect acks", 3'b000, k3)
        `CHK("protect busy", 1'b0, busy)
        rd(9'h000, 1'b1);
        M.stop();
        `CHK("protect data", em[0], q)
        M.start();
        M.wbyte(sb(1'b0, 1'b1, 1'b0), k);
        `CHK("protect chip bit", 1'b1, k)
        M.stop();
        sel0_open <= 1'b0;
        cs = cs0;
        // total erase then a redundant write
        wr(9'h000, 8'hff, 1'b1);
        `CHK("erase busy", 1'b1, busy)
        idle();
        sel2_open <= 1'b0;
        seed = xs(seed);
        rd(seed[8:0], 1'b1);
        M.stop();
        `CHK("erased word", 8'hff, q)
        wr(seed[8:0], 8'hff, 1'b0);
        `CHK("skip both", 1'b0, busy)
        report_and_stop();
    end
endmodule : tb_top
